// >>> src/gate_driver_mode_fsm.sv
// Operating-mode state machine of the isolated gate driver
`timescale 1ns/1ps
`default_nettype none
`include "gate_mode_map.svh"
module gate_driver_mode_fsm #(
  parameter int VMTO_CYCLES = `VMTO_CYCLES
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Asynchronous event inputs
  input  wire logic                   reset_event,
  input  wire logic                   gate_permit,
  input  wire logic                   pwm_command_pin,
  input  wire logic                   collector_saturation_fault,
  input  wire logic                   overcurrent_fault,
  input  wire logic                   secondary_supply_undervoltage,
  input  wire logic                   secondary_supply_overvoltage,
  input  wire logic                   third_supply_undervoltage,
  input  wire logic                   third_supply_overvoltage,
  input  wire logic                   output_tristate,
  input  wire logic                   shoot_through_event,
  input  wire logic                   secondary_timeout_event,
  input  wire logic                   debounce_timeout_event,
  // Configuration bits
  input  wire logic                   uv2_class_b,
  input  wire logic                   ov2_class_b,
  input  wire logic                   uv3_class_b,
  input  wire logic                   ov3_class_b,
  // Command strobes from the serial decoder, same clock
  input  wire logic                   begin_configuration_cmd,
  input  wire logic                   begin_verification_cmd,
  input  wire logic                   finish_configuration_cmd,
  input  wire logic                   clear_sticky_request,
  // Mode and notification outputs
  output logic                        reset_ready_pin,
  output logic [2:0]                  mode_status_field,
  output logic                        enabled_state,
  output logic                        active_state,
  output logic                        fault_a_notify_pin,
  output logic                        fault_b_notify_pin,
  output logic                        gate_on,
  output logic                        weak_on,
  output gate_mode_pkg::turnoff_e     turnoff_req,
  output logic                        config_lock,
  // Error flags
  output logic                        collector_saturation_fault_error_flag,
  output logic                        ocp_error_flag,
  output logic                        permit_error_flag,
  output logic                        uv2_error_flag,
  output logic                        ov2_error_flag,
  output logic                        uv3_error_flag,
  output logic                        ov3_error_flag,
  output logic                        vmto_error_flag,
  output logic                        serial_error_flag,
  output logic                        shoot_through_error_flag,
  output logic                        output_tristate_error_flag,
  output logic                        secondary_timeout_flag,
  output logic                        debounce_timeout_flag
);
  import gate_mode_pkg::*;

  // ----------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------
  localparam int NIN = 13;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;
  assign raw_in = {reset_event, gate_permit, pwm_command_pin, collector_saturation_fault,
                   overcurrent_fault, secondary_supply_undervoltage, secondary_supply_overvoltage,
                   third_supply_undervoltage, third_supply_overvoltage, output_tristate,
                   shoot_through_event, secondary_timeout_event, debounce_timeout_event};
  sync2 #(.W(NIN)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (raw_in),
    .q        (syn)
  );
  logic s_rst, s_en, s_pwm, s_collector_saturation_fault, s_ocp, s_uv2, s_ov2, s_uv3, s_ov3, s_tri, s_stp, s_o2to, s_dbto;
  assign {s_rst, s_en, s_pwm, s_collector_saturation_fault, s_ocp, s_uv2, s_ov2, s_uv3, s_ov3, s_tri, s_stp, s_o2to, s_dbto} = syn;

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    mode_e        mode;
    logic         en_prev;
    logic         cfg_pending;
    logic         wd_run;
    logic [31:0]  wd_cnt;
    logic         vmto_evt;
    logic         rdy;
    logic         nfa;
    logic         nfb;
    logic         gon;
    logic         won;
    turnoff_e     toff;
    logic         lock;
    logic [12:0]  flags;
    logic [2:0]   stat;
    logic         ena;
    logic         act;
  } state_s;
  state_s st_q;
  state_s st_d;

  localparam logic [31:0] WD_LAST = 32'(VMTO_CYCLES - 1);

  logic ev_a;
  logic ev_b;
  logic b_cond;
  logic en_rise;
  logic en_fall;
  logic [12:0] set_f;

  function automatic logic [2:0] mode_index(input mode_e m);
    case (m)
      default_mode:      mode_index = `MODE_DEFAULT;
      error_mode:        mode_index = `MODE_ERROR;
      configuring_mode:  mode_index = `MODE_CONFIGURING;
      configured_mode:   mode_index = `MODE_CONFIGURED;
      active_mode:       mode_index = `MODE_ACTIVE;
      verification_mode: mode_index = `MODE_VERIFICATION;
      weak_active_mode:  mode_index = `MODE_WEAK_ACTIVE;
      default:           mode_index = `MODE_DEFAULT;
    endcase
  endfunction

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    en_rise  = s_en && !st_q.en_prev;
    en_fall  = !s_en && st_q.en_prev;
    ev_a     = s_collector_saturation_fault || s_ocp || en_fall; // R1
    // Supply faults join class B only when configured so; else they stay class C
    b_cond   = (s_uv2 && uv2_class_b) || (s_ov2 && ov2_class_b)
             || (s_uv3 && uv3_class_b) || (s_ov3 && ov3_class_b); // R5 R9
    ev_b     = b_cond || st_q.vmto_evt; // R5 R21
    set_f    = {s_collector_saturation_fault, s_ocp, en_fall, s_uv2, s_ov2, s_uv3, s_ov3, st_q.vmto_evt,
                1'b0, s_stp, s_tri, s_o2to, s_dbto}; // R2 R8

    st_d.en_prev  = s_en;
    st_d.nfa      = 1'b0;
    st_d.nfb      = 1'b0;
    st_d.vmto_evt = 1'b0;
    st_d.toff     = turnoff_none;
    st_d.rdy      = !s_rst; // R11

    // Serial errors for commands outside their modes
    if (begin_configuration_cmd && !(st_q.mode == default_mode || st_q.mode == error_mode))
      set_f[4] = 1'b1; // R25
    if ((begin_verification_cmd || finish_configuration_cmd) && st_q.mode != configuring_mode)
      set_f[4] = 1'b1; // R26

    // Clear wins only where no event sets the same bit in this cycle
    if (clear_sticky_request)
      st_d.flags = set_f; // R15
    else
      st_d.flags = st_q.flags | set_f;

    // Output stage reacts at once, in the same cycle as the mode change
    if (s_collector_saturation_fault || s_ocp)
      st_d.toff = turnoff_safe; // R23 R30
    else if (ev_a || ev_b)
      st_d.toff = turnoff_regular; // R1 R6

    case (st_q.mode)
      default_mode:
      begin
        if (begin_configuration_cmd)
          st_d.mode = configuring_mode; // R17
      end
      error_mode:
      begin
        if (begin_configuration_cmd || st_q.cfg_pending)
        begin
          if (b_cond)
            st_d.cfg_pending = 1'b1; // R16
          else
          begin
            st_d.cfg_pending = 1'b0;
            st_d.mode        = configuring_mode; // R16 R17
          end
        end
        else if (clear_sticky_request && !b_cond)
          st_d.mode = default_mode; // R14 R15
      end
      configuring_mode:
      begin
        if (finish_configuration_cmd)
          st_d.mode = configured_mode; // R18
        else if (begin_verification_cmd)
        begin
          st_d.mode   = verification_mode; // R20
          st_d.wd_run = 1'b1; // R21
          st_d.wd_cnt = '0;
        end
      end
      configured_mode:
      begin
        if (en_rise && !ev_a)
          st_d.mode = active_mode; // R19
      end
      active_mode:
      begin
        if (ev_a)
        begin
          st_d.mode = configured_mode; // R3 R18
          st_d.nfa  = 1'b1; // R4
        end
      end
      verification_mode:
      begin
        if (en_rise && !ev_a)
          st_d.mode = weak_active_mode; // R22
      end
      weak_active_mode:
      begin
        if (ev_a)
        begin
          st_d.mode = verification_mode; // R3 R20
          st_d.nfa  = 1'b1; // R4
        end
      end
      default:
        st_d.mode = default_mode;
    endcase

    // Watchdog keeps counting across weak active, stops once both modes are left
    if (st_q.wd_run)
    begin
      if (st_q.mode != verification_mode && st_q.mode != weak_active_mode)
        st_d.wd_run = 1'b0;
      else if (st_q.wd_cnt == WD_LAST)
      begin
        st_d.wd_run   = 1'b0;
        st_d.vmto_evt = 1'b1; // R21
      end
      else
        st_d.wd_cnt = st_q.wd_cnt + 32'h1; // R22
    end

    // Class B overrides any class A move
    if (ev_b && st_q.mode != error_mode)
    begin
      st_d.mode        = error_mode; // R6 R30 R24
      st_d.nfb         = 1'b1; // R7 R23
      st_d.nfa         = 1'b0;
      st_d.wd_run      = 1'b0;
      st_d.cfg_pending = 1'b0;
    end

    // Reset event forces default mode, flags kept for readback
    if (s_rst)
    begin
      st_d.mode        = default_mode; // R14
      st_d.nfa         = 1'b0;
      st_d.nfb         = 1'b0;
      st_d.wd_run      = 1'b0;
      st_d.cfg_pending = 1'b0;
    end

    st_d.stat = mode_index(st_d.mode); // R27 R29
    st_d.ena  = st_d.mode == active_mode || st_d.mode == weak_active_mode; // R13
    st_d.act  = st_d.mode == active_mode; // R13
    st_d.lock = st_d.mode != configuring_mode; // R2 R17
    // Disabled or tristated stage never turns on
    st_d.gon  = st_d.act && s_pwm && !s_tri && st_d.toff == turnoff_none; // R12
    st_d.won  = st_d.mode == weak_active_mode && s_pwm && !s_tri && st_d.toff == turnoff_none; // R22
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st_q <= '{mode: default_mode, toff: turnoff_none, lock: 1'b1, default: '0};
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign reset_ready_pin            = st_q.rdy;
  assign mode_status_field          = st_q.stat;
  assign enabled_state              = st_q.ena;
  assign active_state               = st_q.act;
  assign fault_a_notify_pin         = st_q.nfa;
  assign fault_b_notify_pin         = st_q.nfb;
  assign gate_on                    = st_q.gon;
  assign weak_on                    = st_q.won;
  assign turnoff_req                = st_q.toff;
  assign config_lock                = st_q.lock;
  assign collector_saturation_fault_error_flag           = st_q.flags[12];
  assign ocp_error_flag             = st_q.flags[11];
  assign permit_error_flag          = st_q.flags[10];
  assign uv2_error_flag             = st_q.flags[9];
  assign ov2_error_flag             = st_q.flags[8];
  assign uv3_error_flag             = st_q.flags[7];
  assign ov3_error_flag             = st_q.flags[6];
  assign vmto_error_flag            = st_q.flags[5];
  assign serial_error_flag          = st_q.flags[4];
  assign shoot_through_error_flag   = st_q.flags[3];
  assign output_tristate_error_flag = st_q.flags[2];
  assign secondary_timeout_flag     = st_q.flags[1];
  assign debounce_timeout_flag      = st_q.flags[0];
endmodule
`default_nettype wire

// >>> src/gate_mode_map.svh
// Constants for the gate driver operating-mode state machine
// Function
// R1: Saturation, overcurrent and permit falling edge are class A events.
// R2: Class A sets its error flag; configuration stays untouched.
// R3: Class A moves active to configured, weak active to verification, else holds.
// R4: Class A notify pulses only when class A changes the mode.
// R5: Secondary supply faults, verification timeout, optional third supply faults are class B.
// R6: Class B starts regular turn-off, sets flag, enters error mode.
// R7: Class B notify pulses only on entry into error mode.
// R8: Class C errors are reported without any mode change.
// R9: Per supply setting selects class B or class C reaction.
// R10: Host must reconfigure after class B shutdown before enabling.
// R11: Reset/ready pin is high whenever no reset event is active.
// R12: Disabled state ignores turn-on and drives turn-off unless tristated.
// R13: Enabled only in active or weak active; active state only in active.
// R14: Reset or clear sticky in error mode enters default mode.
// R15: Clear sticky with class B still present keeps error mode, clears stickies.
// R16: Begin-configuration in error mode waits for class B to clear, no error.
// R17: Configuring mode entered only by begin-configuration in default or error.
// R18: Configured mode from finish-configuration or class A in active.
// R19: Active mode only on permit rising edge in configured mode.
// R20: Verification from begin-verification in configuring or class A in weak active.
// R21: Configuring to verification starts watchdog; expiry is a class B event.
// R22: Permit rising edge in verification enters weak active, watchdog keeps running.
// R23: Turn-off reacts at once; notifies assert with the mode transition.
// R24: Mode changes allowed during a fault; new notification may follow.
// R25: Begin-configuration outside default or error is discarded with serial error.
// R26: Begin-verification and finish-configuration outside configuring flag serial error.
// R27: Current mode is always readable in the mode status field.
// R28: Host reactivates after class A by driving permit low then high.
// R29: Mode status field is the 3-bit mode index, zero to six.
// R30: Coincident class A and B: error mode wins, safe turn-off kept.
`ifndef GATE_MODE_MAP_SVH
`define GATE_MODE_MAP_SVH
`define MODE_DEFAULT      3'h0
`define MODE_ERROR        3'h1
`define MODE_CONFIGURING  3'h2
`define MODE_CONFIGURED   3'h3
`define MODE_ACTIVE       3'h4
`define MODE_VERIFICATION 3'h5
`define MODE_WEAK_ACTIVE  3'h6
`define VMTO_TIME_US      1000
`define CLK_MHZ           25
`define VMTO_CYCLES       (`VMTO_TIME_US * `CLK_MHZ)
`endif

// >>> src/gate_mode_pkg.sv
// Types for the gate driver operating-mode state machine
package gate_mode_pkg;
  typedef enum logic [6:0] {
    default_mode      = 7'h01,
    error_mode        = 7'h02,
    configuring_mode  = 7'h04,
    configured_mode   = 7'h08,
    active_mode       = 7'h10,
    verification_mode = 7'h20,
    weak_active_mode  = 7'h40
  } mode_e;
  typedef enum logic [1:0] {
    turnoff_none    = 2'h0,
    turnoff_regular = 2'h1,
    turnoff_safe    = 2'h2
  } turnoff_e;
endpackage

// >>> src/sync2.sv
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> bench/host_model.sv
// Host model: turns bench requests into command strobes and the permit level
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Requests from the bench
  input  wire logic       req,
  input  wire logic [2:0] op,
  // Towards the device
  output logic            begin_configuration_cmd,
  output logic            begin_verification_cmd,
  output logic            finish_configuration_cmd,
  output logic            clear_sticky_request,
  output logic            gate_permit
);
  // Strobes last one cycle, as a serial decoder would give them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      begin_configuration_cmd <= 1'b0;
      begin_verification_cmd <= 1'b0;
      finish_configuration_cmd <= 1'b0;
      clear_sticky_request <= 1'b0;
      gate_permit <= 1'b0;
    end
    else
    begin
      begin_configuration_cmd <= req && op == 3'h1;
      begin_verification_cmd <= req && op == 3'h2;
      finish_configuration_cmd <= req && op == 3'h3;
      clear_sticky_request <= req && op == 3'h4;
      // Permit is a level; low then high is the only way back after a fault
      if (req && op[2:1] == 2'h3)
        gate_permit <= op[0];
    end
  end
endmodule
`default_nettype wire

// >>> bench/gate_driver_mode_fsm_properties.sv
// Concurrent checks on the mode state machine ports
`timescale 1ns/1ps
`default_nettype none
module mode_checker #(
  parameter int VMTO_CYCLES = 20
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Commands
  input wire logic       begin_configuration_cmd,
  input wire logic       begin_verification_cmd,
  input wire logic       finish_configuration_cmd,
  // Observed outputs
  input wire logic [2:0] mode_status_field,
  input wire logic       enabled_state,
  input wire logic       active_state,
  input wire logic       fault_a_notify_pin,
  input wire logic       fault_b_notify_pin,
  input wire logic       gate_on,
  input wire logic       weak_on,
  input wire logic       serial_error_flag
);
  logic [2:0] m;
  int         vcnt_q;
  assign m = mode_status_field;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Stay in verification or weak active; the watchdog must cut it short
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      vcnt_q <= 0;
    else
      vcnt_q <= (m == 3'h5 || m == 3'h6) ? vcnt_q + 1 : 0;
  end
  property p_enable; enabled_state == (m == 3'h4 || m == 3'h6); endproperty
  a_enable: assert property (p_enable) else $error("enable level off mode");
  property p_active; active_state == (m == 3'h4); endproperty
  a_active: assert property (p_active) else $error("active level off mode");
  property p_fault_a; fault_a_notify_pin |->
    ($past(m) == 3'h4 && m == 3'h3) || ($past(m) == 3'h6 && m == 3'h5); endproperty
  a_fault_a: assert property (p_fault_a) else $error("class A notify without transition");
  property p_fault_b; fault_b_notify_pin |-> m == 3'h1 && $past(m) != 3'h1; endproperty
  a_fault_b: assert property (p_fault_b) else $error("class B notify without entry");
  property p_config; m == 3'h2 && $past(m) != 3'h2 |-> $past(m) <= 3'h1; endproperty
  a_config: assert property (p_config) else $error("configuring entered from wrong mode");
  property p_configured; m == 3'h3 && $past(m) != 3'h3 |-> $past(m) == 3'h2 || $past(m) == 3'h4; endproperty
  a_configured: assert property (p_configured) else $error("configured entered from wrong mode");
  property p_activ; m == 3'h4 && $past(m) != 3'h4 |-> $past(m) == 3'h3; endproperty
  a_activ: assert property (p_activ) else $error("active entered from wrong mode");
  property p_weak; m == 3'h6 && $past(m) != 3'h6 |-> $past(m) == 3'h5; endproperty
  a_weak: assert property (p_weak) else $error("weak active entered from wrong mode");
  property p_cfg_refuse; begin_configuration_cmd && m > 3'h1 |=> serial_error_flag && $stable(m); endproperty
  a_cfg_refuse: assert property (p_cfg_refuse) else $error("refused configure not flagged");
  property p_vf_refuse; (begin_verification_cmd || finish_configuration_cmd) && m != 3'h2 |=>
    serial_error_flag; endproperty
  a_vf_refuse: assert property (p_vf_refuse) else $error("refused command not flagged");
  property p_range; m <= 3'h6; endproperty
  a_range: assert property (p_range) else $error("mode index out of range");
  property p_disabled; !enabled_state && !$past(enabled_state) |-> !gate_on && !weak_on; endproperty
  a_disabled: assert property (p_disabled) else $error("gate driven while disabled");
  property p_watchdog; vcnt_q <= VMTO_CYCLES + 3; endproperty
  a_watchdog: assert property (p_watchdog) else $error("verification stay too long");
endmodule
bind gate_driver_mode_fsm mode_checker #(.VMTO_CYCLES(VMTO_CYCLES)) u_mode_checker (
  .core_clk(core_clk), .rst(rst), .begin_configuration_cmd(begin_configuration_cmd),
  .begin_verification_cmd(begin_verification_cmd), .finish_configuration_cmd(finish_configuration_cmd),
  .mode_status_field(mode_status_field), .enabled_state(enabled_state), .active_state(active_state),
  .fault_a_notify_pin(fault_a_notify_pin), .fault_b_notify_pin(fault_b_notify_pin), .gate_on(gate_on),
  .weak_on(weak_on), .serial_error_flag(serial_error_flag)
);
`default_nettype wire

// >>> bench/gate_driver_mode_fsm_bench.sv
// Self-checking bench for the gate driver mode state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module gate_driver_mode_fsm_bench;
  import gate_mode_pkg::*;
  localparam int VMTO = 40;
  logic core_clk = 0, rst = 1, req = 0, reset_event = 0, pwm_command_pin = 0;
  logic [2:0] op = 0;
  logic collector_saturation_fault = 0, overcurrent_fault = 0, secondary_supply_undervoltage = 0;
  logic secondary_supply_overvoltage = 0, third_supply_undervoltage = 0, third_supply_overvoltage = 0;
  logic output_tristate = 0, shoot_through_event = 0, secondary_timeout_event = 0, debounce_timeout_event = 0;
  logic uv2_class_b = 1, ov2_class_b = 1, uv3_class_b = 0, ov3_class_b = 1;
  wire logic begin_configuration_cmd, begin_verification_cmd, finish_configuration_cmd;
  wire logic clear_sticky_request, gate_permit;
  logic reset_ready_pin, enabled_state, active_state, fault_a_notify_pin, fault_b_notify_pin, gate_on, weak_on;
  logic config_lock, collector_saturation_fault_error_flag, ocp_error_flag, permit_error_flag, uv2_error_flag, ov2_error_flag;
  logic uv3_error_flag, ov3_error_flag, vmto_error_flag, serial_error_flag, shoot_through_error_flag;
  logic output_tristate_error_flag, secondary_timeout_flag, debounce_timeout_flag;
  logic [2:0] mode_status_field;
  turnoff_e turnoff_req;
  int err_count = 0, tests_run = 0, na = 0, nb = 0, cyc = 0, k, r, n0, t0;
  gate_driver_mode_fsm #(.VMTO_CYCLES(VMTO)) u_gate_driver_mode_fsm (.core_clk, .rst, .reset_event, .gate_permit,
    .pwm_command_pin, .collector_saturation_fault, .overcurrent_fault, .secondary_supply_undervoltage,
    .secondary_supply_overvoltage, .third_supply_undervoltage, .third_supply_overvoltage, .output_tristate,
    .shoot_through_event, .secondary_timeout_event, .debounce_timeout_event, .uv2_class_b, .ov2_class_b,
    .uv3_class_b, .ov3_class_b, .begin_configuration_cmd, .begin_verification_cmd, .finish_configuration_cmd,
    .clear_sticky_request, .reset_ready_pin, .mode_status_field, .enabled_state, .active_state,
    .fault_a_notify_pin, .fault_b_notify_pin, .gate_on, .weak_on, .turnoff_req, .config_lock, .collector_saturation_fault_error_flag,
    .ocp_error_flag, .permit_error_flag, .uv2_error_flag, .ov2_error_flag, .uv3_error_flag, .ov3_error_flag,
    .vmto_error_flag, .serial_error_flag, .shoot_through_error_flag, .output_tristate_error_flag,
    .secondary_timeout_flag, .debounce_timeout_flag);
  host_model u_host_model (.core_clk, .rst, .req, .op, .begin_configuration_cmd, .begin_verification_cmd,
    .finish_configuration_cmd, .clear_sticky_request, .gate_permit);
  always #20 core_clk = ~core_clk;
  // Notify pulses last one cycle, so they are counted at every edge
  always @(posedge core_clk)
  begin
    cyc++;
    if (fault_a_notify_pin === 1'b1) na++;
    if (fault_b_notify_pin === 1'b1) nb++;
  end
  function automatic logic [2:0] after_a(input logic [2:0] m);
    return m == 3'h4 ? 3'h3 : m == 3'h6 ? 3'h5 : m;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic host(input logic [2:0] o);
    op = o;
    req = 1;
    tick(1);
    req = 0;
    tick(1);
  endtask
  task automatic wait_mode(input logic [2:0] e);
    for (k = 0; k < 60 && mode_status_field !== e; k++) tick(1);
    `CHK(mode_status_field, e)
  endtask
  task automatic wrap_up;
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // The run needs well under a thousand cycles; ten thousand means a hang
  initial
  begin
    #400000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(38687));
    tick(4);
    rst = 0;
    tick(5);
    `CHK({reset_ready_pin, mode_status_field}, 4'h8)
    host(3'h2);
    tick(1);
    `CHK({serial_error_flag, mode_status_field}, 4'h8)
    host(3'h1);
    `CHK({config_lock, mode_status_field}, 4'h2)
    host(3'h1);
    tick(1);
    `CHK(mode_status_field, 3'h2)
    host(3'h3);
    `CHK(mode_status_field, 3'h3)
    host(3'h7);
    wait_mode(3'h4);
    `CHK({enabled_state, active_state}, 2'h3)
    for (int i = 0; i < 8; i++)
    begin
      pwm_command_pin = 1'($urandom);
      r = $urandom_range(2);
      tick(4);
      `CHK(gate_on, pwm_command_pin)
      n0 = na;
      if (r == 0) collector_saturation_fault = 1;
      else if (r == 1) overcurrent_fault = 1;
      else host(3'h6);
      wait_mode(after_a(3'h4));
      tick(1);
      `CHK(na, n0 + 1)
      `CHK(r == 0 ? collector_saturation_fault_error_flag : r == 1 ? ocp_error_flag : permit_error_flag, 1'b1)
      if (r < 2) `CHK(turnoff_req, turnoff_safe)
      collector_saturation_fault = 0;
      overcurrent_fault = 0;
      host(3'h6);
      tick(4);
      `CHK({na, gate_on}, {n0 + 1, 1'b0})
      host(3'h7);
      wait_mode(3'h4);
    end
    n0 = nb;
    secondary_supply_undervoltage = 1;
    wait_mode(3'h1);
    tick(1);
    `CHK({nb, uv2_error_flag, turnoff_req}, {n0 + 1, 1'b1, turnoff_regular})
    secondary_supply_overvoltage = 1;
    secondary_supply_undervoltage = 0;
    tick(5);
    `CHK(nb, n0 + 1)
    host(3'h4);
    tick(3);
    `CHK({uv2_error_flag, mode_status_field}, 4'h1)
    host(3'h1);
    tick(5);
    `CHK({serial_error_flag, mode_status_field}, 4'h1)
    secondary_supply_overvoltage = 0;
    wait_mode(3'h2);
    for (int i = 0; i < 5; i++)
    begin
      {output_tristate, shoot_through_event, secondary_timeout_event, debounce_timeout_event,
        third_supply_undervoltage} = 5'h1 << i;
      tick(5);
      `CHK(mode_status_field, 3'h2)
    end
    `CHK({output_tristate_error_flag, shoot_through_error_flag, secondary_timeout_flag, debounce_timeout_flag,
      uv3_error_flag}, 5'h1f)
    // Tristate left high would block the weak turn-on check further down
    output_tristate = 0;
    ov3_class_b = 1'($urandom);
    third_supply_overvoltage = 1;
    tick(5);
    `CHK({ov2_error_flag, ov3_error_flag, mode_status_field}, {2'h3, ov3_class_b ? 3'h1 : 3'h2})
    third_supply_overvoltage = 0;
    tick(4);
    host(3'h1);
    wait_mode(3'h2);
    host(3'h6);
    host(3'h2);
    t0 = cyc;
    `CHK(mode_status_field, 3'h5)
    host(3'h7);
    wait_mode(3'h6);
    pwm_command_pin = 1;
    tick(4);
    `CHK({enabled_state, active_state, weak_on}, 3'h5)
    n0 = na;
    host(3'h6);
    wait_mode(after_a(3'h6));
    host(3'h7);
    wait_mode(3'h6);
    `CHK(na, n0 + 1)
    wait_mode(3'h1);
    `CHK({vmto_error_flag, (cyc - t0) inside {[VMTO - 1:VMTO + 4]}}, 2'h3)
    pwm_command_pin = 0;
    host(3'h4);
    wait_mode(3'h0);
    host(3'h1);
    reset_event = 1;
    wait_mode(3'h0);
    `CHK(reset_ready_pin, 1'b0)
    reset_event = 0;
    tick(5);
    `CHK(reset_ready_pin, 1'b1)
    host(3'h1);
    host(3'h3);
    host(3'h6);
    host(3'h7);
    wait_mode(3'h4);
    collector_saturation_fault = 1;
    secondary_supply_undervoltage = 1;
    wait_mode(3'h1);
    `CHK(turnoff_req, turnoff_safe)
    wrap_up();
  end
endmodule
`default_nettype wire
